/* hw/ras_pkg.sv */
// package for the return address stack: register indices, field positions,
// reset values and the carrier structs shared with the core sequencer.
// assumes a 32-bit classic wishbone bus with word addressing (index * 4).
package ras_pkg;

  localparam int PC_W    = 13;
  localparam int PTR_W   = 3;
  localparam int DEPTH_W = 4;
  localparam int IDX_W   = 8;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PROCESSOR_FLAGS = 8'h86;
  localparam logic [IDX_W-1:0] IDX_STACK_POINTER   = 8'hEF;
  localparam logic [IDX_W-1:0] IDX_ENTRY_BASE      = 8'hF0;
  localparam logic [IDX_W-1:0] IDX_ENTRY_LAST      = 8'hFF;
  localparam logic [IDX_W-1:0] IDX_EVENT_STATUS    = 8'hE0;
  localparam logic [IDX_W-1:0] IDX_EVENT_CLEAR     = 8'hE1;
  localparam logic [IDX_W-1:0] IDX_EVENT_ENABLE    = 8'hE2;

  // field positions
  localparam int FLAG_OVF_BIT  = 4;
  localparam int SP_GIE_BIT    = 7;
  localparam int SP_LVDM_BIT   = 6;
  localparam int SP_LVDH_BIT   = 5;
  localparam int HIGH_PC_W     = 5;
  localparam int EV_OVF_BIT    = 0;
  localparam int EV_UNF_BIT    = 1;
  localparam int EV_W          = 2;

  // reset values and the full-stack depth
  localparam logic [PTR_W-1:0]   PTR_RESET   = 3'h7;
  localparam logic [DEPTH_W-1:0] DEPTH_FULL  = 4'h8;
  localparam logic [DEPTH_W-1:0] DEPTH_EMPTY = 4'h0;
  localparam logic [PC_W-1:0]    ENTRY_RESET = 13'h0000;

  typedef enum logic {
    WB_IDLE = 1'b0,
    WB_ACK  = 1'b1
  } wb_state_e;

  // request from the instruction sequencer, one-cycle strobes
  typedef struct packed {
    logic            callPush;
    logic            irqPush;
    logic            subroutineExit;
    logic            handlerExit;
    logic [PC_W-1:0] pc;
  } stack_req_s;

  // answer to the sequencer
  typedef struct packed {
    logic            valid;
    logic            fromHandler;
    logic [PC_W-1:0] pc;
  } stack_rsp_s;

endpackage : ras_pkg

/* hw/return_address_stack.sv */
// return address stack for the 8-bit core: eight 13-bit entries, pointer,
// sticky overflow flag, event status/enable/clear and a classic wishbone slave.
// assumes the sequencer drives one-cycle push/pop strobes on mclk and that
// the low-voltage indicators come from logic on the same clock.
//
// Function
// - eight-level last-in first-out return stack
// - three-bit pointer in stack pointer bits 2:0
// - entries hold 13-bit pc, high and low bytes
// - push decrements pointer, pop increments it
// - call or interrupt entry pushes the pc
// - push writes entry at current level, 111 fills entry0
// - both return kinds pop and reload pc
// - pop restores latest pc, pointer to next free
// - strict last-in first-out ordering of entries
// - pointer and sixteen buffer bytes mapped in bank zero
// - read-only overflow flag bit 4 at 086h
// - ninth nested push sets overflow flag
// - overflow flag cleared only by system reset
// - stack pointer bit 7 is interrupt enable, resets 0
module return_address_stack #(
  parameter int ADR_W = 10
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  // wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // core sequencer
  input  ras_pkg::stack_req_s       stackReq,
  output ras_pkg::stack_rsp_s       stackRsp,
  // status to and from the rest of the core
  input  wire logic                 lowVoltageMidIndicator,
  input  wire logic                 lowVoltageHighIndicator,
  output logic                      globalIrqEnable,
  output logic                      stackOverflowFlag,
  output logic                      irq
);
  import ras_pkg::*;

  logic [PC_W-1:0]    stackEntry [8];
  logic [PTR_W-1:0]   stackLevelBits;
  logic [DEPTH_W-1:0] depth;
  logic [EV_W-1:0]    eventStatus;
  logic [EV_W-1:0]    eventEnable;
  wb_state_e          wbState;

  logic [IDX_W-1:0]   regIdx;
  logic               wbReq;
  logic               wbWrite;
  logic               entryHit;
  logic [PTR_W-1:0]   entrySel;
  logic               entryHighSel;
  logic               doPush;
  logic               doPop;
  logic [PTR_W-1:0]   pushSlot;
  logic [PTR_W-1:0]   popPtr;
  logic [PTR_W-1:0]   popSlot;
  logic [EV_W-1:0]    eventSet;
  logic [31:0]        next_rdata;

  // bus decode
  assign regIdx       = wb_adr_i[ADR_W-1:2];
  assign wbReq        = wb_cyc_i & wb_stb_i & (wbState == WB_IDLE);
  assign wbWrite      = wbReq & wb_we_i & wb_sel_i[0];
  assign entryHit     = (regIdx >= IDX_ENTRY_BASE) && (regIdx <= IDX_ENTRY_LAST);
  assign entrySel     = regIdx[PTR_W:1];
  assign entryHighSel = regIdx[0];

  // a push and a pop in the same cycle cannot come from one instruction;
  // the push is kept so that the return address is never lost
  assign doPush = stackReq.callPush | stackReq.irqPush;
  assign doPop  = (stackReq.subroutineExit | stackReq.handlerExit) & ~doPush;

  // slot arithmetic: entry index is the inverted pointer
  assign pushSlot = ~stackLevelBits;
  assign popPtr   = stackLevelBits + 3'h1;
  assign popSlot  = ~popPtr;

  // events: ninth push on a full stack, pop on an empty one
  always_comb begin
    eventSet = '0;
    eventSet[EV_OVF_BIT] = doPush && (depth == DEPTH_FULL);
    eventSet[EV_UNF_BIT] = doPop && (depth == DEPTH_EMPTY);
  end

  // bus handshake: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wbState <= WB_IDLE;
    end else begin
      case (wbState)
        WB_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            wbState <= WB_ACK;
          end
        end
        WB_ACK: begin
          wbState <= WB_IDLE;
        end
        default: begin
          wbState <= WB_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_o = (wbState == WB_ACK);

  // stack pointer field
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stackLevelBits <= PTR_RESET;
    end else if (wbWrite && regIdx == IDX_STACK_POINTER) begin
      stackLevelBits <= wb_dat_i[PTR_W-1:0];
    end else if (doPush) begin
      stackLevelBits <= stackLevelBits - 3'h1;
    end else if (doPop) begin
      stackLevelBits <= popPtr;
    end
  end

  // depth tracks how many entries are live, so overflow can be told from
  // the full-stack pointer value 111; software writes re-derive it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      depth <= DEPTH_EMPTY;
    end else if (wbWrite && regIdx == IDX_STACK_POINTER) begin
      depth <= {1'b0, ~wb_dat_i[PTR_W-1:0]};
    end else if (doPush && depth != DEPTH_FULL) begin
      depth <= depth + 4'h1;
    end else if (doPop && depth != DEPTH_EMPTY) begin
      depth <= depth - 4'h1;
    end
  end

  // global interrupt enable
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      globalIrqEnable <= 1'b0;
    end else if (wbWrite && regIdx == IDX_STACK_POINTER) begin
      globalIrqEnable <= wb_dat_i[SP_GIE_BIT];
    end
  end

  // sticky overflow flag: no bus path clears it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stackOverflowFlag <= 1'b0;
    end else if (eventSet[EV_OVF_BIT]) begin
      stackOverflowFlag <= 1'b1;
    end
  end

  // entry storage; an overflowing push wraps onto entry 0 as the pointer does
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        stackEntry[i] <= ENTRY_RESET;
      end
    end else begin
      if (doPush) begin
        stackEntry[pushSlot] <= stackReq.pc;
      end
      if (wbWrite && entryHit) begin
        if (entryHighSel) begin
          stackEntry[entrySel][PC_W-1:IDX_W] <= wb_dat_i[HIGH_PC_W-1:0];
        end else begin
          stackEntry[entrySel][IDX_W-1:0] <= wb_dat_i[IDX_W-1:0];
        end
      end
    end
  end

  // pop answer to the sequencer, registered
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stackRsp <= '0;
    end else begin
      stackRsp.valid       <= doPop;
      stackRsp.fromHandler <= doPop & stackReq.handlerExit;
      if (doPop) begin
        stackRsp.pc <= stackEntry[popSlot];
      end
    end
  end

  // event status: set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      eventStatus <= '0;
    end else if (wbWrite && regIdx == IDX_EVENT_CLEAR) begin
      eventStatus <= (eventStatus & ~wb_dat_i[EV_W-1:0]) | eventSet;
    end else begin
      eventStatus <= eventStatus | eventSet;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      eventEnable <= '0;
    end else if (wbWrite && regIdx == IDX_EVENT_ENABLE) begin
      eventEnable <= wb_dat_i[EV_W-1:0];
    end
  end

  assign irq = |(eventStatus & eventEnable);

  // read mux; unmapped indices read zero and still get an ack
  always_comb begin
    next_rdata = '0;
    if (entryHit) begin
      if (entryHighSel) begin
        next_rdata[HIGH_PC_W-1:0] = stackEntry[entrySel][PC_W-1:IDX_W];
      end else begin
        next_rdata[IDX_W-1:0] = stackEntry[entrySel][IDX_W-1:0];
      end
    end else begin
      case (regIdx)
        IDX_PROCESSOR_FLAGS: begin
          next_rdata[FLAG_OVF_BIT] = stackOverflowFlag;
        end
        IDX_STACK_POINTER: begin
          next_rdata[SP_GIE_BIT]  = globalIrqEnable;
          next_rdata[SP_LVDM_BIT] = lowVoltageMidIndicator;
          next_rdata[SP_LVDH_BIT] = lowVoltageHighIndicator;
          next_rdata[PTR_W-1:0]   = stackLevelBits;
        end
        IDX_EVENT_STATUS: begin
          next_rdata[EV_W-1:0] = eventStatus;
        end
        IDX_EVENT_ENABLE: begin
          next_rdata[EV_W-1:0] = eventEnable;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wb_dat_o <= '0;
    end else if (wbReq) begin
      wb_dat_o <= next_rdata;
    end
  end

endmodule // return_address_stack

/* tb/ras_chk.sv */
// checker for the return address stack ports
// assumes ras_pkg is compiled first; one clock domain, mclk
module ras_chk (
  // clock and reset
  input wire logic            mclk,
  input wire logic            resetn,
  // bus and core side
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic            wb_ack_o,
  input ras_pkg::stack_req_s  stackReq,
  input ras_pkg::stack_rsp_s  stackRsp,
  input wire logic            globalIrqEnable,
  input wire logic            stackOverflowFlag
);
  timeunit 1ns;
  timeprecision 1ns;
  import ras_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic push = stackReq.callPush | stackReq.irqPush;
  wire logic pop = stackReq.subroutineExit | stackReq.handlerExit;
  sequence push_s; push && !pop; endsequence
  sequence pop_s; pop && !push; endsequence
  sequence idle_s; !push && !pop; endsequence
  pop_answer_a: assert property (pop_s |=> stackRsp.valid && stackRsp.fromHandler == $past(stackReq.handlerExit))
    else $error("pop not answered");
  lifo_order_a: assert property (push_s ##1 idle_s ##1 pop_s |=> stackRsp.pc == $past(stackReq.pc, 3))
    else $error("pop returned wrong pc");
  rsp_hold_a: assert property (!stackRsp.valid |-> $stable(stackRsp.pc))
    else $error("return pc moved without pop");
  ovf_sticky_a: assert property (stackOverflowFlag |=> stackOverflowFlag)
    else $error("overflow flag cleared");
  ovf_cause_a: assert property ($rose(stackOverflowFlag) |-> $past(push))
    else $error("overflow without push");
  gie_write_a: assert property ($changed(globalIrqEnable) |-> wb_ack_o && wb_we_i)
    else $error("interrupt enable moved without write");
  ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule // ras_chk

bind return_address_stack ras_chk u_chk (
  .mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .stackReq(stackReq), .stackRsp(stackRsp),
  .globalIrqEnable(globalIrqEnable), .stackOverflowFlag(stackOverflowFlag)
);

/* tb/seq_model.sv */
// sequencer model: one-cycle push and pop strobes into the stack
// assumes ras_pkg is compiled first; changes follow a rising mclk
module seq_model (
  // clock
  input  wire logic           mclk,
  // request to the stack
  output ras_pkg::stack_req_s stackReq
);
  timeunit 1ns;
  timeprecision 1ns;
  import ras_pkg::*;
  initial stackReq = '0;
  // k = {call, irq entry, subroutine exit, handler exit}
  task automatic op(input logic [3:0] k, input logic [12:0] p);
    @(posedge mclk);
    stackReq <= {k, p};
    @(posedge mclk);
    // idle pc is inverted so a stale value never passes as live
    stackReq <= {4'h0, ~p};
  endtask
endmodule // seq_model

/* tb/testbench.sv */
// directed testbench for the return address stack
// assumes package, design, checker and sequencer model are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ras_pkg::*;
  logic        mclk, ack, global_irq_enable, ovf, irq;
  logic        resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0]  adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic [7:0]  q;
  logic [12:0] pcs [8];
  stack_req_s  stackReq;
  stack_rsp_s  stackRsp;
  int          n_mismatch = 0, n_tests = 0;
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  return_address_stack uut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .stackReq(stackReq),
    .stackRsp(stackRsp), .lowVoltageMidIndicator(1'b1), .lowVoltageHighIndicator(1'b0),
    .globalIrqEnable(global_irq_enable), .stackOverflowFlag(ovf), .irq(irq));
  seq_model seq (.mclk(mclk), .stackReq(stackReq));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stuck(input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    stuck(n, 16);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk($sformatf("register %h", idx), {8'h0, exp}, {8'h0, q});
  endtask
  task automatic pop(input logic [3:0] k, input logic [12:0] exp);
    int n;
    seq.op(k, 13'h0000);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (stackRsp.valid !== 1'b1 && n < 8);
    stuck(n, 8);
    chk("return pc", {3'h0, exp}, {3'h0, stackRsp.pc});
    chk("handler kind", {15'h0, k[0]}, {15'h0, stackRsp.fromHandler});
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rd(IDX_STACK_POINTER, 8'h47);
    rd(IDX_PROCESSOR_FLAGS, 8'h00);
    bus(1'b1, IDX_STACK_POINTER, 8'h87);
    rd(IDX_STACK_POINTER, 8'hC7);
    chk("irq enable pin", 16'h1, {15'h0, global_irq_enable});
    bus(1'b1, IDX_STACK_POINTER, 8'h07);
    rd(8'h10, 8'h00);
    $display("registers done");
    for (int i = 0; i < 8; i++) begin
      pcs[i] = 13'h1A5C ^ 13'(i * 291);
      seq.op(i[0] ? 4'h4 : 4'h8, pcs[i]);
    end
    rd(IDX_STACK_POINTER, 8'h47);
    rd(IDX_ENTRY_BASE, pcs[0][7:0]);
    rd(IDX_ENTRY_LAST, {3'h0, pcs[7][12:8]});
    rd(IDX_PROCESSOR_FLAGS, 8'h00);
    for (int i = 7; i >= 0; i--) begin
      pop(i[0] ? 4'h1 : 4'h2, pcs[i]);
    end
    seq.op(4'h8, 13'h0123);
    pop(4'h2, 13'h0123);
    rd(IDX_STACK_POINTER, 8'h47);
    $display("push and pop done");
    bus(1'b1, IDX_EVENT_ENABLE, 8'h01);
    for (int i = 0; i < 9; i++) begin
      seq.op(4'h8, 13'h0ABC);
    end
    rd(IDX_PROCESSOR_FLAGS, 8'h10);
    chk("irq", 16'h1, {15'h0, irq});
    chk("overflow pin", 16'h1, {15'h0, ovf});
    bus(1'b1, IDX_PROCESSOR_FLAGS, 8'h00);
    rd(IDX_PROCESSOR_FLAGS, 8'h10);
    rd(IDX_EVENT_STATUS, 8'h01);
    bus(1'b1, IDX_EVENT_ENABLE, 8'h00);
    chk("irq masked", 16'h0, {15'h0, irq});
    bus(1'b1, IDX_EVENT_ENABLE, 8'h01);
    bus(1'b1, IDX_EVENT_CLEAR, 8'h01);
    chk("irq cleared", 16'h0, {15'h0, irq});
    rd(IDX_EVENT_STATUS, 8'h00);
    $display("overflow done");
    bus(1'b1, IDX_STACK_POINTER, 8'h05);
    bus(1'b1, 8'hF2, 8'hAB);
    bus(1'b1, 8'hF3, 8'h1F);
    pop(4'h2, 13'h1FAB);
    $display("override done");
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(IDX_PROCESSOR_FLAGS, 8'h00);
    rd(IDX_ENTRY_BASE, 8'h00);
    chk("overflow pin reset", 16'h0, {15'h0, ovf});
    pop(4'h2, 13'h0000);
    rd(IDX_EVENT_STATUS, 8'h02);
    rd(IDX_STACK_POINTER, 8'h40);
    $display("reset done");
    finish_test();
  end
endmodule // testbench
